//--- dv/bmp_host_model.sv
// Host side of the multifunction pins: pull-ups with wired-AND low drives.
// Assumes a pad pulls low only while its enable is high and its data is low.
`timescale 1ns/1ps
module bmp_host_model
(
	// Host controls
	input wire logic holdLow,
	input wire logic trigLow,
	// Device pad drive
	input wire logic lineOe,
	input wire logic lineOut,
	input wire logic pinBOe,
	input wire logic pinBOut,
	// Resolved pad levels
	output logic lineLevel,
	output logic pinBLevel
);
	// Pull-up wins unless someone pulls low; never shows a stale value
	assign lineLevel = !(holdLow || (lineOe && !lineOut));
	assign pinBLevel = !(trigLow || (pinBOe && !pinBOut));
endmodule

//--- dv/boot_mode_pin_function_control_test.sv
// Self-checking bench for the boot-mode pin function control block.
// Assumes the short hibernate and pulse counts set below.
`timescale 1ns/1ps
module boot_mode_pin_function_control_test;
	import bmp_pkg::*;
	localparam int HC = 20;
	localparam int PC = 8;
	logic ref_clk = 0, reset = 1, strap = 0, portSel = 1, bootDone = 0, intA = 0, intB = 0, motEv = 0;
	logic [1:0] cfgA = PIN_PUSH_PULL, cfgB = PIN_PUSH_PULL;
	logic cfgWr = 0, threeW = 0, dOut = 0, dEn = 0, csN = 1, mosi = 0, holdLow = 0, trigLow = 0;
	logic lineIn, lineOut, lineOe, pbIn, pbOut, pbOe, misoOut, misoOe, dataOut, dataOe;
	logic latched, spiMode, spiSel, dataIn, trig, wake, detEn, hib, aIn, bIn;
	int failCount = 0, checkCount = 0, trigCount = 0, wakeCount = 0, n;

	// Free-running 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	// Pulse counters for the one-cycle event outputs
	always @(posedge ref_clk)
	begin
		trigCount += int'(trig === 1'b1);
		wakeCount += int'(wake === 1'b1);
	end

	bmp_pin_control #(.HIB_CYC(HC), .PULSE_CYC(PC)) dut (.ref_clk(ref_clk), .reset(reset),
		.bootModeStrap(strap), .hostPortSelect(portSel), .bootComplete(bootDone), .intLevelA(intA),
		.intLevelB(intB), .motionEvent(motEv), .pinCfgA(cfgA), .pinCfgB(cfgB), .cfgWrite(cfgWr),
		.spiThreeWire(threeW), .spiDataOutCore(dOut), .spiDataOutEn(dEn), .motionLineIn(lineIn),
		.motionLineOut(lineOut), .motionLineOe(lineOe), .pinBIn(pbIn), .pinBOut(pbOut), .pinBOe(pbOe),
		.chipSelectN(csN), .spiMosiIn(mosi), .spiMisoOut(misoOut), .spiMisoOe(misoOe),
		.spiDataOut(dataOut), .spiDataOe(dataOe), .bootModeLatched(latched), .spiMode(spiMode),
		.spiSelected(spiSel), .spiDataIn(dataIn), .measureTrigger(trig), .wakeRequest(wake),
		.detectEnabled(detEn), .hibernate(hib), .intAInput(aIn), .intBInput(bIn));

	bmp_host_model host (.holdLow(holdLow), .trigLow(trigLow), .lineOe(lineOe), .lineOut(lineOut),
		.pinBOe(pbOe), .pinBOut(pbOut), .lineLevel(lineIn), .pinBLevel(pbIn));

	// Inputs always move 1 ns after the rising edge
	task automatic step(input int cyc);
		repeat (cyc) @(posedge ref_clk);
		#1;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp)
		begin
			failCount++;
			$display("unexpected %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// Strap must be stable before release; it latches a few edges later
	task automatic powerOn(input logic s);
		reset = 1;
		strap = s;
		step(5);
		reset = 0;
		step(8);
	endtask

	task automatic loadCfg(input logic [1:0] a, input logic [1:0] b);
		cfgA = a;
		cfgB = b;
		cfgWr = 1;
		step(1);
		cfgWr = 0;
		step(3);
	endtask

	task automatic completeRun();
		$display("checks %0d mismatches %0d", checkCount, failCount);
		if (failCount == 0 && checkCount > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		#200000;
		failCount++;
		completeRun();
	end

	initial
	begin
		powerOn(1'b0);
		check("latched strap", latched, 1'b0);
		check("spi mode", spiMode, 1'b1);
		check("pin A driven", lineOe, 1'b1);
		intA = 1;
		step(3);
		check("pin A level", lineOut, 1'b1);
		loadCfg(PIN_OPEN_DRAIN, PIN_PUSH_PULL);
		check("open-drain high", lineOe, 1'b0);
		intA = 0;
		step(3);
		check("open-drain low", lineOe, 1'b1);
		loadCfg(PIN_OPEN_SOURCE, PIN_PUSH_PULL);
		check("open-source low", lineOe, 1'b0);
		loadCfg(PIN_INPUT, PIN_PUSH_PULL);
		step(4);
		check("pin A input", aIn, 1'b1);
		strap = 1;
		step(10);
		check("strap held", latched, 1'b0);
		csN = 0;
		mosi = 1;
		step(6);
		check("spi selected", spiSel, 1'b1);
		check("serial data in", dataIn, 1'b1);
		threeW = 1;
		dEn = 1;
		dOut = 1;
		step(3);
		check("shared data pin drives", dataOe, 1'b1);
		check("shared data value", dataOut, 1'b1);
		check("miso idle", misoOe, 1'b0);
		threeW = 0;
		step(3);
		check("four-wire miso drives", misoOe, 1'b1);
		check("four-wire data pin idle", dataOe, 1'b0);
		check("miso value", misoOut, 1'b1);
		// Host holds the trigger pin low so releasing the pad makes no false edge
		trigLow = 1;
		loadCfg(PIN_PUSH_PULL, PIN_INPUT);
		check("pin B released", pbOe, 1'b0);
		trigCount = 0;
		trigLow = 0;
		step(6);
		check("pin B input", bIn, 1'b1);
		trigLow = 1;
		step(8);
		check("trigger pulses", trigCount, 1);
		$display("test default mode done");
		trigLow = 0;
		portSel = 0;
		csN = 1;
		powerOn(1'b1);
		check("latched motion", latched, 1'b1);
		check("i2c mode", spiMode, 1'b0);
		check("boot-done low", {pbOe, pbOut}, 2'h2);
		bootDone = 1;
		step(4);
		check("boot-done released", pbOe, 1'b0);
		check("detect on", detEn, 1'b1);
		motEv = 1;
		step(1);
		motEv = 0;
		n = 0;
		repeat (40)
		begin
			n += int'(lineOe === 1'b1 && lineOut === 1'b0);
			step(1);
		end
		check("motion pulse width", n, PC);
		holdLow = 1;
		step(HC / 2);
		holdLow = 0;
		step(8);
		check("short low ignored", hib, 1'b0);
		holdLow = 1;
		step(HC + 10);
		check("hibernate", hib, 1'b1);
		check("detect off", detEn, 1'b0);
		check("pads released", {lineOe, pbOe}, 2'h0);
		check("pin B cmos input", bIn, 1'b1);
		check("pin A not input", aIn, 1'b0);
		wakeCount = 0;
		csN = 0;
		step(8);
		check("no wake", wakeCount, 0);
		check("still asleep", hib, 1'b1);
		csN = 1;
		holdLow = 0;
		step(8);
		check("awake", hib, 1'b0);
		$display("test motion mode done");
		completeRun();
	end
endmodule

//--- logic/bmp_pin_control.sv
// Boot-mode pin function control: multiplexes the multifunction pins by boot strap and interface strap.
// Assumes pin inputs are asynchronous and the core supplies boot done, interrupt and motion events.
`timescale 1ns/1ps
module bmp_pin_control
	import bmp_pkg::*;
#(
	parameter int HIB_CYC = HIB_ENTRY_CYC,
	parameter int PULSE_CYC = MOT_PULSE_CYC
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Straps
	input wire logic bootModeStrap,
	input wire logic hostPortSelect,
	// Core side
	input wire logic bootComplete,
	input wire logic intLevelA,
	input wire logic intLevelB,
	input wire logic motionEvent,
	input wire logic [1:0] pinCfgA,
	input wire logic [1:0] pinCfgB,
	input wire logic cfgWrite,
	input wire logic spiThreeWire,
	input wire logic spiDataOutCore,
	input wire logic spiDataOutEn,
	// Interrupt pin A / motion line
	input wire logic motionLineIn,
	output logic motionLineOut,
	output logic motionLineOe,
	// Interrupt pin B / trigger / boot-done
	input wire logic pinBIn,
	output logic pinBOut,
	output logic pinBOe,
	// Chip select / wake
	input wire logic chipSelectN,
	// SPI data pins
	input wire logic spiMosiIn,
	output logic spiMisoOut,
	output logic spiMisoOe,
	output logic spiDataOut,
	output logic spiDataOe,
	// Status to core
	output logic bootModeLatched,
	output logic spiMode,
	output logic spiSelected,
	output logic spiDataIn,
	output logic measureTrigger,
	output logic wakeRequest,
	output logic detectEnabled,
	output logic hibernate,
	output logic intAInput,
	output logic intBInput
);
	logic [2:0] strapSync, motSync, pinBSync, csSync, mosiSync, selSync;
	logic [1:0] latchCnt_q;
	logic strapDone_q, bootMode_q, hostSel_q, bootDone_q;
	bmp_state_e state_q;
	logic [31:0] lowCnt_q, pulseCnt_q;
	logic [1:0] cfgA_q, cfgB_q;
	logic trigPrev_q, wakePrev_q;
	logic motLow, pinBHigh, csLow, inHib;

	// Three-stage synchronisers for pad inputs; the motion, pin B and chip-select levels need the second and third stages to agree
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			strapSync <= 3'h0;
			motSync <= 3'h7;
			pinBSync <= 3'h0;
			csSync <= 3'h7;
			mosiSync <= 3'h0;
			selSync <= 3'h0;
		end
		else
		begin
			strapSync <= {strapSync[1:0], bootModeStrap};
			motSync <= {motSync[1:0], motionLineIn};
			pinBSync <= {pinBSync[1:0], pinBIn};
			csSync <= {csSync[1:0], chipSelectN};
			mosiSync <= {mosiSync[1:0], spiMosiIn};
			selSync <= {selSync[1:0], hostPortSelect};
		end
	end
	assign motLow = ~motSync[1] & ~motSync[2];
	assign pinBHigh = pinBSync[1] & pinBSync[2];
	assign csLow = ~csSync[1] & ~csSync[2]; // Active-low select
	assign inHib = (state_q == BMP_HIBERNATE);

	// Straps are caught once after reset release, never during reset itself
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			latchCnt_q <= 2'h0;
			strapDone_q <= 1'b0;
			bootMode_q <= 1'b0;
			hostSel_q <= 1'b0;
		end
		else if (!strapDone_q)
		begin
			latchCnt_q <= latchCnt_q + 2'h1;
			if (latchCnt_q == STRAP_LATCH_CYC)
			begin
				strapDone_q <= 1'b1;
				bootMode_q <= strapSync[2]; // Held until next reset
				hostSel_q <= selSync[2]; // Strap pin, synchronised, sampled with boot mode
			end
		end
	end

	// Boot, active and hibernate sequencing
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_q <= BMP_BOOT;
			bootDone_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				BMP_BOOT:
					if (strapDone_q && bootComplete)
					begin
						state_q <= BMP_ACTIVE;
						bootDone_q <= 1'b1; // Release boot-done after boot
					end
				BMP_ACTIVE:
					if (bootMode_q && lowCnt_q >= 32'(HIB_CYC))
						state_q <= BMP_HIBERNATE; // Long host low enters hibernate
				BMP_HIBERNATE:
					if ((bootMode_q && !motLow) || (!bootMode_q && csLow))
						state_q <= BMP_ACTIVE; // Wake pin only in default mode
				default:
					state_q <= BMP_BOOT;
			endcase
		end
	end

	// Host low-time counter; our own pulse is excluded so it cannot self-hibernate
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			lowCnt_q <= 32'h0;
		else if (motLow && pulseCnt_q == 32'h0 && lowCnt_q < 32'(HIB_CYC))
			lowCnt_q <= lowCnt_q + 32'h1;
		else if (!motLow)
			lowCnt_q <= 32'h0;
	end

	// Motion pulse timer
	always_ff @(posedge ref_clk)
	begin
		if (reset)
			pulseCnt_q <= 32'h0;
		else if (pulseCnt_q != 32'h0)
			pulseCnt_q <= pulseCnt_q - 32'h1;
		else if (bootMode_q && state_q == BMP_ACTIVE && !motLow && motionEvent)
			pulseCnt_q <= 32'(PULSE_CYC); // Only while detection is enabled
	end

	// Pin configuration reverts to push-pull at reset and while in hibernate
	always_ff @(posedge ref_clk)
	begin
		if (reset || inHib)
		begin
			cfgA_q <= PIN_PUSH_PULL;
			cfgB_q <= PIN_PUSH_PULL;
		end
		else if (cfgWrite)
		begin
			cfgA_q <= pinCfgA;
			cfgB_q <= pinCfgB;
		end
	end

	// Pad drive, registered so every output comes from a flip-flop
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			motionLineOut <= 1'b0;
			motionLineOe <= 1'b0;
			pinBOut <= 1'b0;
			pinBOe <= 1'b0;
		end
		else if (!strapDone_q || inHib)
		begin
			motionLineOut <= 1'b0; // High impedance in hibernate
			motionLineOe <= 1'b0;
			pinBOut <= 1'b0;
			pinBOe <= !strapDone_q; // Boot-done held low until strap known
		end
		else if (bootMode_q)
		begin
			motionLineOut <= 1'b0;
			motionLineOe <= (pulseCnt_q != 32'h0); // Open-drain low pulse
			pinBOut <= 1'b0;
			pinBOe <= !bootDone_q; // Open-drain boot done
		end
		else
		begin
			motionLineOut <= intLevelA; // Interrupt output A
			case (cfgA_q)
				PIN_PUSH_PULL: motionLineOe <= 1'b1;
				PIN_OPEN_DRAIN: motionLineOe <= ~intLevelA;
				PIN_OPEN_SOURCE: motionLineOe <= intLevelA;
				default: motionLineOe <= 1'b0;
			endcase
			pinBOut <= intLevelB; // Interrupt B or trigger input
			case (cfgB_q)
				PIN_PUSH_PULL: pinBOe <= 1'b1;
				PIN_OPEN_DRAIN: pinBOe <= ~intLevelB;
				PIN_OPEN_SOURCE: pinBOe <= intLevelB;
				default: pinBOe <= 1'b0;
			endcase
		end
	end

	// Trigger and wake pulses, plus status
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			trigPrev_q <= 1'b0;
			wakePrev_q <= 1'b0;
			measureTrigger <= 1'b0;
			wakeRequest <= 1'b0;
			bootModeLatched <= 1'b0;
			spiMode <= 1'b0;
			detectEnabled <= 1'b0;
			hibernate <= 1'b0;
			intAInput <= 1'b0;
			intBInput <= 1'b0;
		end
		else
		begin
			trigPrev_q <= pinBHigh;
			wakePrev_q <= csLow && inHib && !bootMode_q;
			measureTrigger <= !bootMode_q && strapDone_q && !inHib && cfgB_q == PIN_INPUT
				&& pinBHigh && !trigPrev_q; // Rising edge triggers a measurement
			wakeRequest <= csLow && inHib && !bootMode_q && !wakePrev_q;
			bootModeLatched <= bootMode_q;
			spiMode <= hostSel_q;
			detectEnabled <= bootMode_q && state_q == BMP_ACTIVE && !motLow;
			hibernate <= inHib;
			intAInput <= !bootMode_q && (inHib || cfgA_q == PIN_INPUT) && motSync[2]; // CMOS input
			intBInput <= (bootMode_q ? inHib : cfgB_q == PIN_INPUT) && pinBSync[2];
		end
	end

	// Serial pin routing: three-wire shares one data pin, four-wire uses two
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			spiSelected <= 1'b0;
			spiDataIn <= 1'b0;
			spiMisoOut <= 1'b0;
			spiMisoOe <= 1'b0;
			spiDataOut <= 1'b0;
			spiDataOe <= 1'b0;
		end
		else
		begin
			spiSelected <= hostSel_q && csLow && !inHib;
			spiDataIn <= mosiSync[2];
			spiMisoOut <= spiDataOutCore;
			spiMisoOe <= hostSel_q && csLow && !spiThreeWire && spiDataOutEn && !inHib;
			spiDataOut <= spiDataOutCore;
			spiDataOe <= hostSel_q && csLow && spiThreeWire && spiDataOutEn && !inHib;
		end
	end

	// Assertions
	sequence s_pulse_start;
		$rose(motionLineOe) && bootMode_q;
	endsequence
	a_motion_pulse_lowonly: assert property (@(posedge ref_clk) disable iff (reset)
		s_pulse_start |-> !motionLineOut) else $error("motion pulse drives high");
	a_strap_held: assert property (@(posedge ref_clk) disable iff (reset)
		$past(strapDone_q) |-> $stable(bootMode_q)) else $error("boot mode changed after latch");
	a_bootdone_od: assert property (@(posedge ref_clk) disable iff (reset)
		strapDone_q && bootMode_q && pinBOe |-> !pinBOut) else $error("boot-done drives high");
	a_hib_hiz: assert property (@(posedge ref_clk) disable iff (reset)
		inHib |=> !motionLineOe && !pinBOe) else $error("pin driven in hibernate");
	a_hib_no_wake: assert property (@(posedge ref_clk) disable iff (reset)
		bootMode_q |-> !wakeRequest) else $error("wake in motion mode");
	a_cfg_revert: assert property (@(posedge ref_clk) disable iff (reset)
		inHib |=> cfgA_q == PIN_PUSH_PULL && cfgB_q == PIN_PUSH_PULL) else $error("config not reverted");
	a_spi_one_pin: assert property (@(posedge ref_clk) disable iff (reset)
		!(spiMisoOe && spiDataOe)) else $error("both data pins driven");
	a_cs_active_low: assert property (@(posedge ref_clk) disable iff (reset)
		spiSelected |-> $past(csSync[2]) == 1'b0) else $error("selected with cs high");
endmodule

//--- shared/bmp_pkg.sv
// Constants for the boot-mode pin function control block.
// Assumes a single 100 MHz clock and a synchronous active-high reset at power-on.
package bmp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	// Hibernate entry low time, in microseconds; cycles rounded up so a host low is never cut short
	localparam int HIB_ENTRY_US = 1000;
	localparam int HIB_ENTRY_CYC = (HIB_ENTRY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Motion pulse width, in microseconds
	localparam int MOT_PULSE_US = 1000;
	localparam int MOT_PULSE_CYC = (MOT_PULSE_US * 1000) / CLK_PERIOD_NS;
	// Cycles after reset release before the strap is latched
	localparam logic [1:0] STRAP_LATCH_CYC = 2'h3;
	// Pin configuration encodings
	localparam logic [1:0] PIN_PUSH_PULL = 2'h0;
	localparam logic [1:0] PIN_OPEN_DRAIN = 2'h1;
	localparam logic [1:0] PIN_OPEN_SOURCE = 2'h2;
	localparam logic [1:0] PIN_INPUT = 2'h3;
	typedef enum logic [1:0] {BMP_BOOT, BMP_ACTIVE, BMP_HIBERNATE} bmp_state_e;
endpackage
